// ### core/psq_sequencer.sv
// PLL setup sequencer: checks a request, searches multiplier and bus divider,
// loads the clock controls, polls for lock and answers with a result code.
// Assumes requests come from logic on SYS_CLK; PLL_LOCK is asynchronous.
`timescale 1ns/1ps
// What this block does
// - Request of four arguments, answer code plus clock
// - Result codes zero to four as listed
// - Mode decode; exact needs precise target
// - At-most mode never exceeds target
// - At-least mode never below target
// - Nearest mode picks closest either side
// - PLL output kept at most 50 MHz
// - Out-of-range frequencies: bad frequency, echo input
// - Unknown mode: bad mode, echo input
// - No combination: no solution, echo input
// - Bus divider capped at 255
// - Bypass PLL when division alone suffices
// - Load dividers, select PLL when needed
// - Poll limit zero waits forever, else counted
// - Success returns achieved clock in kHz
module psq_sequencer
  import psq_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Request
  input wire logic REQ_VALID,
  input wire logic [31:0] REQ_IN_KHZ,
  input wire logic [31:0] REQ_TARGET_KHZ,
  input wire logic [31:0] REQ_MODE,
  input wire logic [31:0] REQ_POLL_LIMIT,
  output logic BUSY,
  // Answer
  output logic DONE,
  output psq_pkg::psq_result_t RESULT,
  output logic [31:0] CLOCK_KHZ,
  // PLL and clock controls
  input wire logic PLL_LOCK,
  output logic [4:0] PLL_FEEDBACK_DIV,
  output logic [1:0] PLL_POST_DIV,
  output logic [7:0] SYSTEM_BUS_CLOCK_DIVIDER,
  output logic MAIN_CLK_SEL_PLL
);
  import psq_pkg::*;

  typedef struct packed {
    psq_state_t st;
    logic [15:0] in_khz;
    logic [15:0] tgt;
    psq_mode_t mode;
    logic [31:0] limit;
    logic [5:0] m;
    logic [7:0] d;
    logic [5:0] bm;
    logic [7:0] bd;
    logic [23:0] berr;
    logic found;
    logic [31:0] polls;
    logic [1:0] settle;
    psq_result_t res;
    logic [31:0] clk;
    logic done;
    logic div_go;
    logic [4:0] fb;
    logic [1:0] pd;
    logic [7:0] bdiv;
    logic sel;
    logic [4:0] prev_fb;
    logic [1:0] prev_pd;
    logic [7:0] prev_bdiv;
    logic prev_sel;
    logic lock_s1;
    logic lock_s2;
  } psq_state_all_t;

  psq_state_all_t s;
  psq_state_all_t next_s;

  logic [23:0] prod_in;
  logic [23:0] prod_tgt;
  logic [23:0] err;
  logic elig;
  logic [39:0] floor_tgt;
  logic [23:0] div_dividend;
  logic div_done;
  logic [23:0] div_quot;

  // True when e1/d1 is strictly below e2/d2
  function automatic logic ratio_less(input logic [23:0] e1, input logic [7:0] d1,
                                      input logic [23:0] e2, input logic [7:0] d2);
    ratio_less = (32'(e1) * 32'(d2)) < (32'(e2) * 32'(d1));
  endfunction : ratio_less

  // Post divider code from the PLL output frequency
  function automatic logic [1:0] post_code(input logic [23:0] f);
    if (f >= POST_TH1_KHZ) begin
      post_code = 2'h0;
    end else if (f >= POST_TH2_KHZ) begin
      post_code = 2'h1;
    end else if (f >= POST_TH3_KHZ) begin
      post_code = 2'h2;
    end else begin
      post_code = 2'h3;
    end
  endfunction : post_code

  assign div_dividend = 24'(s.in_khz * s.bm);

  psq_divider #(
    .DW(24),
    .VW(8)
  ) u_div (
    .SYS_CLK(SYS_CLK),
    .RESET(RESET),
    .start(s.div_go),
    .dividend(div_dividend),
    .divisor(s.bd),
    .done(div_done),
    .quotient(div_quot)
  );

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.div_go = 1'b0;
    next_s.lock_s1 = PLL_LOCK;
    next_s.lock_s2 = s.lock_s1;
    floor_tgt = 40'(REQ_TARGET_KHZ) * 40'(BUS_DIV_MAX);
    prod_in = 24'(s.in_khz * s.m);
    prod_tgt = 24'(s.tgt * s.d);
    // Candidate clock is prod_in / d; compare against target scaled by d
    case (s.mode)
      MATCH_EXACT: begin
        elig = (prod_in == prod_tgt);
        err = 24'h00_0000;
      end
      MATCH_AT_MOST: begin
        elig = (prod_in <= prod_tgt);
        err = prod_tgt - prod_in;
      end
      MATCH_AT_LEAST: begin
        elig = (prod_in >= prod_tgt);
        err = prod_in - prod_tgt;
      end
      default: begin
        elig = 1'b1;
        err = (prod_in >= prod_tgt) ? (prod_in - prod_tgt) : (prod_tgt - prod_in);
      end
    endcase
    case (s.st)
      ST_IDLE: begin
        if (REQ_VALID) begin
          next_s.in_khz = REQ_IN_KHZ[15:0];
          next_s.tgt = REQ_TARGET_KHZ[15:0];
          next_s.mode = psq_mode_t'(REQ_MODE[1:0]);
          next_s.limit = REQ_POLL_LIMIT;
          next_s.clk = REQ_IN_KHZ;
          if (REQ_IN_KHZ < IN_MIN_KHZ || REQ_IN_KHZ > IN_MAX_KHZ ||
              REQ_TARGET_KHZ < TGT_MIN_KHZ || REQ_TARGET_KHZ > TGT_MAX_KHZ) begin
            next_s.res = RESULT_BAD_FREQUENCY;
            next_s.done = 1'b1;
          end else if (40'(REQ_IN_KHZ) > floor_tgt) begin
            next_s.res = RESULT_BAD_FREQUENCY;
            next_s.done = 1'b1;
          end else if (REQ_MODE > MODE_MAX) begin
            next_s.res = RESULT_BAD_MODE;
            next_s.done = 1'b1;
          end else begin
            next_s.st = ST_SEARCH;
            next_s.m = 6'h01;
            next_s.d = 8'h01;
            next_s.found = 1'b0;
          end
        end
      end
      ST_SEARCH: begin
        if (prod_in > PLL_OUT_MAX_KHZ || s.m > FB_MULT_MAX) begin
          if (s.found) begin
            next_s.st = ST_DIVIDE;
            next_s.div_go = 1'b1;
          end else begin
            next_s.st = ST_IDLE;
            next_s.res = RESULT_NO_SOLUTION;
            next_s.clk = 32'(s.in_khz);
            next_s.done = 1'b1;
          end
        end else begin
          // Multiplier one is tried first, so ties keep the bypass setting
          if (elig && (!s.found || ratio_less(err, s.d, s.berr, s.bd))) begin
            next_s.found = 1'b1;
            next_s.bm = s.m;
            next_s.bd = s.d;
            next_s.berr = err;
          end
          if (s.d == BUS_DIV_MAX) begin
            next_s.d = 8'h01;
            next_s.m = s.m + 6'h01;
          end else begin
            next_s.d = s.d + 8'h01;
          end
        end
      end
      ST_DIVIDE: begin
        if (div_done) begin
          next_s.clk = 32'(div_quot);
          next_s.prev_fb = s.fb;
          next_s.prev_pd = s.pd;
          next_s.prev_bdiv = s.bdiv;
          next_s.prev_sel = s.sel;
          next_s.bdiv = s.bd;
          next_s.polls = 32'h0000_0000;
          next_s.settle = LOCK_SETTLE_CYCLES;
          if (s.bm == 6'h01) begin
            next_s.sel = 1'b0;
            next_s.st = ST_IDLE;
            next_s.res = RESULT_SUCCESS;
            next_s.done = 1'b1;
          end else begin
            next_s.fb = 5'(s.bm - 6'h01);
            next_s.pd = post_code(div_dividend);
            next_s.sel = 1'b1;
            next_s.st = ST_LOCK;
          end
        end
      end
      ST_LOCK: begin
        if (s.settle != 2'h0) begin
          next_s.settle = s.settle - 2'h1;
        end else if (s.lock_s2) begin
          next_s.st = ST_IDLE;
          next_s.res = RESULT_SUCCESS;
          next_s.done = 1'b1;
        end else if (s.limit != 32'h0000_0000 && s.polls == s.limit - 32'h0000_0001) begin
          next_s.fb = s.prev_fb;
          next_s.pd = s.prev_pd;
          next_s.bdiv = s.prev_bdiv;
          next_s.sel = s.prev_sel;
          next_s.clk = 32'(s.in_khz);
          next_s.res = RESULT_LOCK_FAILED;
          next_s.st = ST_IDLE;
          next_s.done = 1'b1;
        end else begin
          next_s.polls = s.polls + 32'h0000_0001;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.res <= RESULT_SUCCESS;
      s.mode <= MATCH_EXACT;
      s.fb <= FB_DIV_RESET;
      s.pd <= POST_DIV_RESET;
      s.bdiv <= BUS_DIV_RESET;
      s.prev_fb <= FB_DIV_RESET;
      s.prev_pd <= POST_DIV_RESET;
      s.prev_bdiv <= BUS_DIV_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign BUSY = (s.st != ST_IDLE);
  assign DONE = s.done;
  assign RESULT = s.res;
  assign CLOCK_KHZ = s.clk;
  assign PLL_FEEDBACK_DIV = s.fb;
  assign PLL_POST_DIV = s.pd;
  assign SYSTEM_BUS_CLOCK_DIVIDER = s.bdiv;
  assign MAIN_CLK_SEL_PLL = s.sel;

endmodule : psq_sequencer

// ### core/psq_pkg.sv
// Constants, codes and state encodings for the PLL setup sequencer.
// Assumes a single 100 MHz system clock domain; frequencies are in kHz.
package psq_pkg;

  // Argument limits
  localparam logic [31:0] IN_MIN_KHZ = 32'h0000_2710;
  localparam logic [31:0] IN_MAX_KHZ = 32'h0000_61a8;
  localparam logic [31:0] TGT_MIN_KHZ = 32'h0000_0001;
  localparam logic [31:0] TGT_MAX_KHZ = 32'h0000_c350;
  localparam logic [23:0] PLL_OUT_MAX_KHZ = 24'h00_c350;
  localparam logic [7:0] BUS_DIV_MAX = 8'hff;
  localparam logic [5:0] FB_MULT_MAX = 6'h20;

  // Post divider choice keeps the oscillator inside its band
  localparam logic [23:0] POST_TH1_KHZ = 24'h01_30b0;
  localparam logic [23:0] POST_TH2_KHZ = 24'h00_9858;
  localparam logic [23:0] POST_TH3_KHZ = 24'h00_4c2c;

  // Reset values of the clock controls
  localparam logic [4:0] FB_DIV_RESET = 5'h00;
  localparam logic [1:0] POST_DIV_RESET = 2'h0;
  localparam logic [7:0] BUS_DIV_RESET = 8'h01;

  // Cycles the lock indicator is ignored after new settings are loaded
  localparam logic [1:0] LOCK_SETTLE_CYCLES = 2'h3;

  localparam logic [31:0] MODE_MAX = 32'h0000_0003;

  typedef enum logic [1:0] {
    MATCH_EXACT = 2'h0,
    MATCH_AT_MOST = 2'h1,
    MATCH_AT_LEAST = 2'h2,
    MATCH_NEAREST = 2'h3
  } psq_mode_t;

  typedef enum logic [2:0] {
    RESULT_SUCCESS = 3'h0,
    RESULT_BAD_FREQUENCY = 3'h1,
    RESULT_BAD_MODE = 3'h2,
    RESULT_NO_SOLUTION = 3'h3,
    RESULT_LOCK_FAILED = 3'h4
  } psq_result_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SEARCH = 5'h02,
    ST_DIVIDE = 5'h04,
    ST_LOCK = 5'h08,
    ST_SPARE = 5'h10
  } psq_state_t;

endpackage : psq_pkg

// ### core/psq_divider.sv
// Sequential restoring divider, one quotient bit per clock.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
module psq_divider #(
  parameter int DW = 24,
  parameter int VW = 8
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Operation
  input wire logic start,
  input wire logic [DW-1:0] dividend,
  input wire logic [VW-1:0] divisor,
  output logic done,
  output logic [DW-1:0] quotient
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [DW-1:0] quo;
    logic [VW:0] rem;
    logic [VW-1:0] dvs;
    logic [5:0] cnt;
  } psq_div_state_t;

  psq_div_state_t s;
  psq_div_state_t next_s;
  logic [VW:0] trial;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    trial = {s.rem[VW-1:0], s.quo[DW-1]};
    if (start) begin
      next_s.busy = 1'b1;
      next_s.quo = dividend;
      next_s.rem = '0;
      next_s.dvs = divisor;
      next_s.cnt = 6'(DW);
    end else if (s.busy) begin
      // Shift in the next dividend bit and subtract when it fits
      next_s.quo = {s.quo[DW-2:0], 1'b0};
      next_s.rem = trial;
      if (trial >= {1'b0, s.dvs}) begin
        next_s.rem = trial - {1'b0, s.dvs};
        next_s.quo[0] = 1'b1;
      end
      next_s.cnt = s.cnt - 6'h01;
      if (s.cnt == 6'h01) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign quotient = s.quo;

endmodule : psq_divider

// ### verif/psq_sequencer_properties.sv
// Port checker for the PLL setup sequencer.
// Assumes one clock domain; bound to every psq_sequencer instance.
`timescale 1ns/1ps
module psq_checker
  import psq_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Request
  input wire logic REQ_VALID,
  input wire logic [31:0] REQ_IN_KHZ,
  input wire logic [31:0] REQ_TARGET_KHZ,
  input wire logic [31:0] REQ_MODE,
  input wire logic BUSY,
  // Answer
  input wire logic DONE,
  input psq_pkg::psq_result_t RESULT,
  input wire logic [31:0] CLOCK_KHZ,
  // PLL side
  input wire logic PLL_LOCK,
  input wire logic [4:0] PLL_FEEDBACK_DIV,
  input wire logic [7:0] SYSTEM_BUS_CLOCK_DIVIDER,
  input wire logic MAIN_CLK_SEL_PLL
);
  logic [31:0] cap_in;
  logic take;
  logic succ;
  logic freq_bad;
  assign take = REQ_VALID && !BUSY;
  assign succ = DONE && RESULT == RESULT_SUCCESS;
  assign freq_bad = REQ_IN_KHZ < IN_MIN_KHZ || REQ_IN_KHZ > IN_MAX_KHZ || REQ_TARGET_KHZ < TGT_MIN_KHZ
    || REQ_TARGET_KHZ > TGT_MAX_KHZ || REQ_IN_KHZ > REQ_TARGET_KHZ * 32'h0000_00ff;
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      cap_in <= 32'h0;
    end else if (take) begin
      cap_in <= REQ_IN_KHZ;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  property p_done_idle;
    DONE |-> !BUSY;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("Busy while answering");
  property p_bad_freq;
    take && freq_bad |=> DONE && RESULT == RESULT_BAD_FREQUENCY && CLOCK_KHZ == $past(REQ_IN_KHZ);
  endproperty
  a_bad_freq: assert property (p_bad_freq) else $error("Bad frequency not refused");
  property p_bad_mode;
    take && !freq_bad && REQ_MODE > MODE_MAX |=> DONE && RESULT == RESULT_BAD_MODE;
  endproperty
  a_bad_mode: assert property (p_bad_mode) else $error("Bad mode not refused");
  property p_echo;
    DONE && RESULT != RESULT_SUCCESS |-> CLOCK_KHZ == cap_in;
  endproperty
  a_echo: assert property (p_echo) else $error("Input clock not echoed");
  property p_untouched;
    DONE && RESULT inside {RESULT_BAD_FREQUENCY, RESULT_BAD_MODE, RESULT_NO_SOLUTION} |->
      $stable(PLL_FEEDBACK_DIV) && $stable(SYSTEM_BUS_CLOCK_DIVIDER) && $stable(MAIN_CLK_SEL_PLL);
  endproperty
  a_untouched: assert property (p_untouched) else $error("Controls changed on refusal");
  property p_pll_max;
    succ && MAIN_CLK_SEL_PLL |-> cap_in * ({27'h0, PLL_FEEDBACK_DIV} + 32'h1) <= 32'h0000_c350;
  endproperty
  a_pll_max: assert property (p_pll_max) else $error("PLL output above limit");
  property p_clock_calc;
    succ |-> CLOCK_KHZ == cap_in * (MAIN_CLK_SEL_PLL ? {27'h0, PLL_FEEDBACK_DIV} + 32'h1 : 32'h1)
      / {24'h0, SYSTEM_BUS_CLOCK_DIVIDER};
  endproperty
  a_clock_calc: assert property (p_clock_calc) else $error("Clock differs from controls");
  property p_lock_seen;
    succ && MAIN_CLK_SEL_PLL |-> $past(PLL_LOCK, 3);
  endproperty
  a_lock_seen: assert property (p_lock_seen) else $error("Success without lock");
  property p_lock_fail;
    DONE && RESULT == RESULT_LOCK_FAILED |-> !$past(PLL_LOCK, 3);
  endproperty
  a_lock_fail: assert property (p_lock_fail) else $error("Lock failure while locked");
endmodule : psq_checker
bind psq_sequencer psq_checker i_chk (.SYS_CLK, .RESET, .REQ_VALID, .REQ_IN_KHZ, .REQ_TARGET_KHZ, .REQ_MODE,
  .BUSY, .DONE, .RESULT, .CLOCK_KHZ, .PLL_LOCK, .PLL_FEEDBACK_DIV, .SYSTEM_BUS_CLOCK_DIVIDER, .MAIN_CLK_SEL_PLL);

// ### verif/psq_pll_model.sv
// Behavioural PLL: lock rises a set number of cycles after the multiplier settles.
// Assumes settings come from the sequencer on the same clock.
`timescale 1ns/1ps
module psq_pll_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Settings and behaviour
  input wire logic [4:0] fb_div,
  input wire logic sel,
  input wire logic can_lock,
  input wire logic [7:0] lock_delay,
  // Lock status
  output logic lock
);
  logic [4:0] last_fb;
  logic [7:0] age;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_fb <= 5'h00;
      age <= 8'h00;
      lock <= 1'b0;
    end else begin
      last_fb <= fb_div;
      age <= (fb_div != last_fb) ? 8'h00 : (age == 8'hff ? age : age + 8'h01);
      lock <= can_lock && sel && fb_div == last_fb && age >= lock_delay;
    end
  end
endmodule : psq_pll_model

// ### verif/psq_sequencer_tb.sv
// Self-checking bench: integer search model against the sequencer.
// Assumes the checker bind and the PLL model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module psq_sequencer_tb;
  import psq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vld = 1'b0;
  logic can = 1'b1;
  logic [7:0] dly = 8'h00;
  logic [31:0] in_k = 32'h0, tgt_k = 32'h0, mode = 32'h0, lim = 32'h0, clk_k;
  logic done, lock, sel, busy;
  logic [4:0] fb;
  logic [1:0] pd;
  logic [7:0] bdv;
  psq_result_t res;
  int seed = 32'h5cc5ad5a;
  int checked = 0, miscompares = 0, cycles = 0;
  psq_sequencer i_dut (.SYS_CLK(clk), .RESET(rst), .REQ_VALID(vld), .REQ_IN_KHZ(in_k), .REQ_TARGET_KHZ(tgt_k),
    .REQ_MODE(mode), .REQ_POLL_LIMIT(lim), .BUSY(busy), .DONE(done), .RESULT(res), .CLOCK_KHZ(clk_k),
    .PLL_LOCK(lock), .PLL_FEEDBACK_DIV(fb), .PLL_POST_DIV(pd),
    .SYSTEM_BUS_CLOCK_DIVIDER(bdv), .MAIN_CLK_SEL_PLL(sel));
  psq_pll_model i_pll (.clk(clk), .rst(rst), .fb_div(fb), .sel(sel), .can_lock(can), .lock_delay(dly), .lock(lock));
  always #5 clk = ~clk;
  function automatic void model(input int unsigned in, t, md, output int unsigned er, ek, output bit pll,
                                output int unsigned fo, dv);
    longint unsigned bn, bd, n, e, be;
    bit hit;
    hit = 0;
    bn = 0;
    bd = 1;
    be = 0;
    pll = 0;
    er = 1;
    ek = in;
    if (in < 10000 || in > 25000 || t < 1 || t > 50000 || in > t * 255) return;
    er = 2;
    if (md > 3) return;
    for (int m = 1; m <= 32 && in * m <= 50000; m++) begin
      for (int d = 1; d <= 255; d++) begin
        n = in * m;
        e = n > t * d ? n - t * d : t * d - n;
        if ((md == 0 && e == 0 && !hit) || (md == 1 && n <= t * d && (!hit || n * bd > bn * d)) ||
            (md == 2 && n >= t * d && (!hit || n * bd < bn * d)) || (md == 3 && (!hit || e * bd < be * d))) begin
          hit = 1;
          bn = n;
          bd = d;
          be = e;
          pll = m > 1;
        end
      end
    end
    er = hit ? 0 : 3;
    if (hit) ek = bn / bd;
    fo = 32'(bn);
    dv = 32'(bd);
  endfunction : model
  task automatic go(input int unsigned in, t, md, l, input bit ok);
    int unsigned er, ek, fo, dv;
    bit pll;
    int n;
    logic [1:0] pe;
    model(in, t, md, er, ek, pll, fo, dv);
    pe = fo >= POST_TH1_KHZ ? 2'h0 : fo >= POST_TH2_KHZ ? 2'h1 : fo >= POST_TH3_KHZ ? 2'h2 : 2'h3;
    if (er == 0 && pll && !ok) begin
      er = 4;
      ek = in;
    end
    @(posedge clk);
    in_k <= in;
    tgt_k <= t;
    mode <= md;
    lim <= l;
    can <= ok;
    dly <= l ? 8'h00 : 8'($unsigned($random(seed)) % 60);
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    @(negedge clk);
    `CHK(busy, 1'(er != 1 && er != 2))
    n = 1;
    while (done !== 1'b1 && n < 9000) begin
      @(negedge clk);
      n++;
    end
    `CHK(done, 1'b1)
    `CHK(res, 3'(er))
    `CHK(clk_k, ek)
    if (er == 0) `CHK(sel, pll)
    if (er == 0) `CHK(bdv, 8'(dv))
    if (er == 0 && pll) `CHK(pd, pe)
    $display("Test end: in=%0d target=%0d mode=%0d code=%0d", in, t, md, er);
  endtask : go
  task automatic tally_and_finish;
    $display("Counts: checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK(bdv, 8'h01)
    go(9999, 1000, 0, 0, 1);
    go(25001, 1000, 0, 0, 1);
    go(12000, 60000, 0, 0, 1);
    go(12000, 0, 1, 0, 1);
    go(12000, 40, 1, 0, 1);
    go(10000, 40, 3, 0, 1);
    go(12000, 25000, 4, 0, 1);
    go(12000, 25000, 32'hffffffff, 0, 1);
    go(12000, 25000, 0, 0, 1);
    go(12000, 25000, 1, 2400, 1);
    go(12000, 25000, 2, 0, 1);
    go(12000, 25000, 2, 3600, 1);
    go(12000, 16500, 3, 0, 1);
    go(25000, 50000, 0, 3, 0);
    go(25000, 50000, 0, 3, 1);
    go(10000, 5000, 0, 1, 0);
    for (int i = 0; i < 16; i++) begin
      go(10000 + $unsigned($random(seed)) % 15001, 1 + $unsigned($random(seed)) % 50000, i % 4, 0, 1);
    end
    tally_and_finish;
  end
endmodule : psq_sequencer_tb
